// File: core/cfg_if.sv
// Carrier between the decoder top and its decode and rate helpers.
// Assumes one clock; all members are driven synchronously to it.
`timescale 1ns/1ps
`default_nettype none
interface cfg_if;
    import psmd_pkg::*;
    logic [3:0] code;
    mode_t      mode;
    cfg_t       cfg;
    logic       run;
    logic       mod_tick;
    logic       odr_tick;
    modport decode (input code, output mode);
    modport ticker (input cfg, input run, output mod_tick, output odr_tick);
    modport top    (output code, output cfg, output run,
                    input mode, input mod_tick, input odr_tick);
endinterface : cfg_if
`default_nettype wire

// File: core/pin_strap_mode_decoder.sv
// Pin-strapped configuration, standby and status header for eight channels.
// Assumes all pins are synchronous to ref_clk_i (the master clock).
//
// Summary of operation
// - Four pins form one code for all channels
// - Codes 0-3 eco standard, divide 1,2,4,8
// - Codes 4-7 median standard, divide 1,2,4,8
// - Codes 8-B fast standard, divide 1,2,4,8
// - Codes C-F one-shot: eco, median, fast, fast; divide 1,1,2,1
// - Modulator divider 4 fast, 8 median, 32 eco
// - Power mode sets bias and clock together
// - Faults reported in every non-standby channel header
// - Header bit 7 flags fault, needs reset
// - Header carries settle, type and saturation
// - 32 bits per channel per output period
// - Bank standby pin high disables four channels
// - Standby channel slot sends all zeros
// - Low pin stops 0-3, high 4-7
// - Channel 0 standby disables common-mode output
// - Channel 4 standby disables crystal drive
// - Control port uses SPI mode 0 edges
// - Host pulses sync after configuration change
// - Two pins pick decimation 32/64/128/1024
// - Filter pin high sinc5, low wideband
`timescale 1ns/1ps
`default_nettype none
`include "psmd_params.svh"
module pin_strap_mode_decoder
    import psmd_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    // Strap pins
    input  wire logic [3:0]  op_select_pins_i,
    input  wire logic        bank_low_standby_i,
    input  wire logic        bank_high_standby_i,
    input  wire logic        filter_sel_i,
    input  wire logic        decim_sel_hi_i,
    input  wire logic        decim_sel_lo_i,
    input  wire logic        sync_i,
    // Converter core status and results
    input  wire logic        crc_err_i,
    input  wire logic        mem_flip_i,
    input  wire logic        clk_missing_i,
    input  wire logic [7:0]  sat_i,
    input  wire logic [191:0] sample_i,
    // Analog controls
    output logic [1:0]       bias_level_o,
    output logic [5:0]       mod_div_o,
    output logic             common_mode_out_en_o,
    output logic             xtal_en_o,
    // Serial data
    output logic             data_ready_o,
    output logic             serial_data_clock_o,
    output logic [7:0]       serial_data_out_o,
    // Control port
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_mosi_i,
    input  wire logic [15:0] spi_resp_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_o,
    output logic [15:0]      spi_cmd_o,
    output logic             spi_cmd_valid_o
);
    // ==============================================================
    // State
    typedef struct packed {
        logic [3:0]  code;
        logic        sinc5;
        logic [1:0]  dec;
        logic [1:0]  st;
        logic        sync_q;
    } pins_t;
    typedef struct packed {
        pins_t       pins;
        cfg_t        act;
        logic        run;
        logic        fault;
        logic        nsettled;
        logic        sync_prev;
        logic [7:0][31:0] sh;
        logic [5:0]  bit_cnt;
        logic [2:0]  div_cnt;
        logic        drdy;
        logic        serial_data_clock;
        logic [7:0]  dout;
        logic        sclk_q;
        logic        cs_q;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [3:0]  spi_cnt;
        logic        miso;
        logic [15:0] cmd;
        logic        cmd_valid;
    } top_state_t;
    top_state_t s_reg, s_next;
    cfg_if ci ();
    logic [7:0][31:0] word_w;
    logic [10:0] decim_w;
    logic [7:0]  stby_w;
    logic        sync_edge;
    logic [2:0]  div_max;
    // ==============================================================
    // Helpers
    // one shared code
    assign ci.code = s_reg.pins.code;
    assign ci.cfg  = s_reg.act;
    // Counters restart at sync, so a new divider starts clean
    assign ci.run  = s_reg.run && !sync_edge;
    strap_decode u_decode (.c(ci));
    rate_ticker  u_ticker (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .c(ci));
    // ==============================================================
    // Pin decode
    // decimation pins
    always_comb begin
        unique case (s_reg.pins.dec)
            2'b00: decim_w = `DECIM_32;
            2'b01: decim_w = `DECIM_64;
            2'b10: decim_w = `DECIM_128;
            2'b11: decim_w = `DECIM_1024;
        endcase
    end
    assign stby_w    = {{4{s_reg.pins.st[1]}}, {4{s_reg.pins.st[0]}}};
    assign sync_edge = s_reg.pins.sync_q && !s_reg.sync_prev;
    assign div_max   = 3'((4'h1 << s_reg.act.mode.data_clock_divider) - 4'h1);
    // ==============================================================
    // Per-channel output word
    for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_word
        logic [7:0] hdr;
        always_comb begin
            hdr                = 8'h00;
            hdr[2:0]           = 3'(ch);
            hdr[`HDR_FAULT]    = s_reg.fault;
            hdr[`HDR_NSETTLED] = s_reg.nsettled;
            hdr[`HDR_FTYPE]    = s_reg.act.sinc5;
            hdr[`HDR_SAT]      = sat_i[ch];
        end
        assign word_w[ch] = s_reg.act.standby[ch] ? 32'h0000_0000 :
                            {hdr, sample_i[ch*`DATA_BITS +: `DATA_BITS]};
    end
    // ==============================================================
    // Next state
    always_comb begin
        s_next           = s_reg;
        s_next.drdy      = 1'b0;
        s_next.cmd_valid = 1'b0;
        s_next.pins.code  = op_select_pins_i;
        s_next.pins.sinc5 = filter_sel_i;
        s_next.pins.dec   = {decim_sel_hi_i, decim_sel_lo_i};
        s_next.pins.st    = {bank_high_standby_i, bank_low_standby_i};
        s_next.pins.sync_q = sync_i;
        s_next.sync_prev   = s_reg.pins.sync_q;
        if (crc_err_i || mem_flip_i || clk_missing_i) begin
            s_next.fault = 1'b1;
        end
        if (sync_edge) begin
            s_next.act.mode    = ci.mode;
            s_next.act.sinc5   = s_reg.pins.sinc5;
            s_next.act.decim   = decim_w;
            s_next.act.standby = stby_w;
            s_next.run         = 1'b1;
            s_next.nsettled    = 1'b1;
        end else if (ci.odr_tick) begin
            if (s_reg.act.mode.one_shot) begin
                s_next.run = 1'b0;
            end
        end
        if (ci.odr_tick && !sync_edge) begin
            s_next.sh       = word_w;
            s_next.bit_cnt  = `WORD_BITS;
            s_next.div_cnt  = 3'h0;
            s_next.drdy     = 1'b1;
            s_next.serial_data_clock     = 1'b0;
            s_next.nsettled = 1'b0;
        end else if (s_reg.bit_cnt != 6'h00) begin
            s_next.div_cnt = (s_reg.div_cnt == div_max) ? 3'h0 : s_reg.div_cnt + 3'h1;
            s_next.serial_data_clock    = (s_reg.div_cnt == 3'h0);
            if (s_reg.div_cnt == 3'h0) begin
                for (int i = 0; i < `NUM_CH; i++) begin
                    s_next.dout[i] = s_reg.sh[i][31];
                    s_next.sh[i]   = {s_reg.sh[i][30:0], 1'b0};
                end
                s_next.bit_cnt = s_reg.bit_cnt - 6'h01;
            end
        end else begin
            s_next.serial_data_clock = 1'b0;
        end
        s_next.sclk_q = spi_sclk_i;
        s_next.cs_q   = spi_cs_n_i;
        if (s_reg.cs_q && !spi_cs_n_i) begin
            s_next.tx      = spi_resp_i;
            s_next.miso    = spi_resp_i[15];
            s_next.spi_cnt = 4'h0;
        end else if (!spi_cs_n_i && !s_reg.sclk_q && spi_sclk_i) begin
            s_next.rx      = {s_reg.rx[14:0], spi_mosi_i};
            s_next.spi_cnt = s_reg.spi_cnt + 4'h1;
            if (s_reg.spi_cnt == 4'hF) begin
                s_next.cmd       = {s_reg.rx[14:0], spi_mosi_i};
                s_next.cmd_valid = 1'b1;
            end
        end else if (!spi_cs_n_i && s_reg.sclk_q && !spi_sclk_i) begin
            s_next.tx   = {s_reg.tx[14:0], 1'b0};
            s_next.miso = s_reg.tx[14];
        end
    end
    // ==============================================================
    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_reg                 <= '0;
            s_reg.cs_q            <= 1'b1;
            s_reg.act.mode.mod_div <= `MOD_DIV_ECO;
            s_reg.act.mode.data_clock_divider <= DIV8;
            s_reg.act.sinc5       <= 1'b1;
            s_reg.act.decim       <= `DECIM_1024;
        end else begin
            s_reg <= s_next;
        end
    end
    // ==============================================================
    // Outputs
    // bias and divider move together
    assign bias_level_o         = s_reg.act.mode.power;
    assign mod_div_o            = s_reg.act.mode.mod_div;
    assign common_mode_out_en_o = !s_reg.act.standby[0];
    assign xtal_en_o            = !s_reg.act.standby[4];
    assign data_ready_o         = s_reg.drdy;
    assign serial_data_clock_o  = s_reg.serial_data_clock;
    assign serial_data_out_o    = s_reg.dout;
    assign spi_miso_o           = s_reg.miso;
    assign spi_miso_oe_o        = !s_reg.cs_q;
    assign spi_cmd_o            = s_reg.cmd;
    assign spi_cmd_valid_o      = s_reg.cmd_valid;
    // ==============================================================
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    property p_eco_band;
        ci.code[3:2] == 2'b00 |-> ci.mode.power == PWR_ECO && !ci.mode.one_shot
            && ci.mode.data_clock_divider == data_clock_divider_t'(ci.code[1:0]);
    endproperty
    a_eco_band: assert property (p_eco_band) else $error("eco band decode wrong");
    property p_median_band;
        ci.code[3:2] == 2'b01 |-> ci.mode.power == PWR_MEDIAN && !ci.mode.one_shot
            && ci.mode.data_clock_divider == data_clock_divider_t'(ci.code[1:0]);
    endproperty
    a_median_band: assert property (p_median_band) else $error("median decode wrong");
    property p_fast_band;
        ci.code[3:2] == 2'b10 |-> ci.mode.power == PWR_FAST && !ci.mode.one_shot
            && ci.mode.data_clock_divider == data_clock_divider_t'(ci.code[1:0]);
    endproperty
    a_fast_band: assert property (p_fast_band) else $error("fast decode wrong");
    property p_one_shot;
        ci.code == 4'hE |-> ci.mode.one_shot && ci.mode.power == PWR_FAST
            && ci.mode.data_clock_divider == DIV2;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot decode wrong");
    property p_mod_div;
        s_reg.act.mode.power == PWR_MEDIAN |-> mod_div_o == 6'h08;
    endproperty
    a_mod_div: assert property (p_mod_div) else $error("modulator divider wrong");
    property p_fault;
        crc_err_i |=> s_reg.fault [*8];
    endproperty
    a_fault: assert property (p_fault) else $error("fault flag not sticky");
    property p_hold_cfg;
        !sync_edge |=> $stable(s_reg.act);
    endproperty
    a_hold_cfg: assert property (p_hold_cfg) else $error("config changed without sync");
    sequence s_load;
        ci.odr_tick && !sync_edge ##1 data_ready_o && s_reg.bit_cnt == 6'h20;
    endsequence
    property p_load;
        ci.odr_tick && !sync_edge |-> s_load;
    endproperty
    a_load: assert property (p_load) else $error("data ready not issued");
    property p_standby_zero;
        data_ready_o && s_reg.act.standby[4] |-> s_reg.sh[5] == 32'h0000_0000;
    endproperty
    a_standby_zero: assert property (p_standby_zero) else $error("standby slot not zero");
    property p_vcm;
        $rose(s_reg.act.standby[0]) |-> !common_mode_out_en_o;
    endproperty
    a_vcm: assert property (p_vcm) else $error("common-mode output left on");
    property p_stby_map;
        sync_edge |=> s_reg.act.standby[3:0] == {4{$past(s_reg.pins.st[0])}}
            && s_reg.act.standby[7:4] == {4{$past(s_reg.pins.st[1])}};
    endproperty
    a_stby_map: assert property (p_stby_map) else $error("bank standby map wrong");
    property p_decim_max;
        sync_edge && s_reg.pins.dec == 2'b11 |=> s_reg.act.decim == 11'h400;
    endproperty
    a_decim_max: assert property (p_decim_max) else $error("decimation wrong");
    property p_filter;
        sync_edge |=> s_reg.act.sinc5 == $past(s_reg.pins.sinc5);
    endproperty
    a_filter: assert property (p_filter) else $error("filter select wrong");
    property p_xtal;
        xtal_en_o |-> !s_reg.act.standby[4];
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal drive left on");
    property p_first_bit;
        data_ready_o |=> serial_data_clock_o;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit strobe missing");
    property p_cmd_pulse;
        spi_cmd_valid_o |=> !spi_cmd_valid_o;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe too long");
    property p_miso_first;
        s_reg.cs_q && !spi_cs_n_i |=> spi_miso_o == $past(spi_resp_i[15]);
    endproperty
    a_miso_first: assert property (p_miso_first) else $error("first reply bit wrong");
    property p_fault_other;
        mem_flip_i || clk_missing_i |=> s_reg.fault;
    endproperty
    a_fault_other: assert property (p_fault_other) else $error("fault flag not set");
    property p_fast_div;
        s_reg.act.mode.power == PWR_FAST |-> mod_div_o == 6'h04;
    endproperty
    a_fast_div: assert property (p_fast_div) else $error("fast divider wrong");
    property p_one_shot_stop;
        ci.odr_tick && s_reg.act.mode.one_shot && !sync_edge |=> !s_reg.run;
    endproperty
    a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");
    property p_nsettled;
        sync_edge |=> s_reg.nsettled;
    endproperty
    a_nsettled: assert property (p_nsettled) else $error("settle flag not raised");
endmodule : pin_strap_mode_decoder
`default_nettype wire

// File: core/psmd_params.svh
// Constants for the pin-strap mode decoder: dividers, ratios, header bits.
// Assumes the includer works in the master clock domain.
`ifndef PSMD_PARAMS_SVH
`define PSMD_PARAMS_SVH
`define NUM_CH          8
`define WORD_BITS       6'h20
`define DATA_BITS       24
`define MOD_DIV_FAST    6'h04
`define MOD_DIV_MEDIAN  6'h08
`define MOD_DIV_ECO     6'h20
`define DECIM_32        11'h020
`define DECIM_64        11'h040
`define DECIM_128       11'h080
`define DECIM_1024      11'h400
`define HDR_FAULT       7
`define HDR_NSETTLED    6
`define HDR_FTYPE       5
`define HDR_SAT         4
`endif

// File: core/psmd_pkg.sv
// Types shared by the pin-strap mode decoder and its helpers.
// Assumes nothing beyond a SystemVerilog elaborator.
package psmd_pkg;
    typedef enum logic [1:0] {PWR_ECO = 2'b00, PWR_MEDIAN = 2'b01, PWR_FAST = 2'b10} power_t;
    typedef enum logic [1:0] {DIV1 = 2'b00, DIV2 = 2'b01, DIV4 = 2'b10, DIV8 = 2'b11} data_clock_divider_t;
    typedef struct packed {
        power_t    power;
        data_clock_divider_t data_clock_divider;
        logic      one_shot;
        logic [5:0] mod_div;
    } mode_t;
    typedef struct packed {
        mode_t       mode;
        logic        sinc5;
        logic [10:0] decim;
        logic [7:0]  standby;
    } cfg_t;
endpackage : psmd_pkg

// File: core/rate_ticker.sv
// Modulator tick and output-data-rate tick from the master clock.
// Assumes cfg stays stable while run is high.
`timescale 1ns/1ps
`default_nettype none
`include "psmd_params.svh"
module rate_ticker
    import psmd_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    cfg_if.ticker     c
);
    typedef struct packed {
        logic [5:0]  mod_cnt;
        logic [10:0] dec_cnt;
    } tick_state_t;
    tick_state_t st_reg, st_next;
    logic mod_tick, odr_tick;
    always_comb begin
        st_next  = st_reg;
        mod_tick = c.run && (st_reg.mod_cnt == c.cfg.mode.mod_div - 6'h01);
        odr_tick = mod_tick && (st_reg.dec_cnt == c.cfg.decim - 11'h001);
        if (!c.run) begin
            st_next = '0;
        end else if (mod_tick) begin
            st_next.mod_cnt = '0;
            st_next.dec_cnt = odr_tick ? 11'h000 : st_reg.dec_cnt + 11'h001;
        end else begin
            st_next.mod_cnt = st_reg.mod_cnt + 6'h01;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign c.mod_tick = mod_tick;
    assign c.odr_tick = odr_tick;
endmodule : rate_ticker
`default_nettype wire

// File: core/strap_decode.sv
// Combinational decode of the 4-bit operating code.
// Assumes the code is already registered by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "psmd_params.svh"
module strap_decode
    import psmd_pkg::*;
(
    cfg_if.decode c
);
    mode_t m;
    always_comb begin
        m          = '0;
        m.data_clock_divider = data_clock_divider_t'(c.code[1:0]);
        unique case (c.code[3:2])
            2'b00: m.power = PWR_ECO;
            2'b01: m.power = PWR_MEDIAN;
            2'b10: m.power = PWR_FAST;
            2'b11: begin
                // one-shot table
                // One-shot codes pick their own divider
                m.one_shot = 1'b1;
                m.data_clock_divider = (c.code[1:0] == 2'b10) ? DIV2 : DIV1;
                unique case (c.code[1:0])
                    2'b00:   m.power = PWR_ECO;
                    2'b01:   m.power = PWR_MEDIAN;
                    default: m.power = PWR_FAST;
                endcase
            end
        endcase
        unique case (m.power)
            PWR_FAST:   m.mod_div = `MOD_DIV_FAST;
            PWR_MEDIAN: m.mod_div = `MOD_DIV_MEDIAN;
            default:    m.mod_div = `MOD_DIV_ECO;
        endcase
    end
    assign c.mode = m;
endmodule : strap_decode
`default_nettype wire

// File: tb/host_reader.sv
// Host-side model that reads the eight serial data lines of the decoder.
// Assumes data ready and the bit strobe are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Serial data from the device
    input  wire logic             data_ready_i,
    input  wire logic             bit_strobe_i,
    input  wire logic [7:0]       data_i,
    // Captured words and timing
    output logic      [7:0][31:0] word_o,
    output logic      [5:0]       bits_o,
    output logic      [7:0]       gap_o,
    output logic      [15:0]      words_o
);
    logic [7:0] cnt_reg;

    // =====================================================
    // Word capture
    // host shifts 32 bits
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            words_o <= 16'h0000;
        end else if (data_ready_i) begin
            words_o <= words_o + 16'h0001;
        end
        if (srst_i || data_ready_i) begin
            bits_o  <= 6'h00;
            cnt_reg <= 8'h01;
        end else if (bit_strobe_i) begin
            for (int c = 0; c < 8; c++) begin
                word_o[c] <= {word_o[c][30:0], data_i[c]};
            end
            bits_o  <= bits_o + 6'h01;
            // Spacing between strobes gives the divider
            gap_o   <= cnt_reg;
            cnt_reg <= 8'h01;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : host_reader
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the pin-strap mode decoder with a host reader.
// Assumes the design files and psmd_params.svh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "psmd_params.svh"
module tb_top;
    import psmd_pkg::*;
    localparam int LIMIT = 95000;
    logic ref_clk_i, srst_i, sync_i, filter_sel_i, decim_sel_hi_i, decim_sel_lo_i;
    logic [3:0] op_select_pins_i;
    logic bank_low_standby_i, bank_high_standby_i, crc_err_i, mem_flip_i, clk_missing_i;
    logic [7:0] sat_i, serial_data_out_o;
    logic [191:0] sample_i;
    logic [1:0] bias_level_o;
    logic [5:0] mod_div_o;
    logic common_mode_out_en_o, xtal_en_o, data_ready_o, serial_data_clock_o;
    logic spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, spi_cmd_valid_o;
    logic [15:0] spi_resp_i, spi_cmd_o, got_cmd, hcount;
    logic [7:0][31:0] hw;
    logic [5:0] hbits;
    logic [7:0] hgap;
    int num_errors = 0, comparisons = 0, cycles = 0, p, rec;
    int dec_tab[4] = '{32, 64, 128, 1024};

    pin_strap_mode_decoder uut (.ref_clk_i, .srst_i, .op_select_pins_i, .bank_low_standby_i,
        .bank_high_standby_i, .filter_sel_i, .decim_sel_hi_i, .decim_sel_lo_i, .sync_i,
        .crc_err_i, .mem_flip_i, .clk_missing_i, .sat_i, .sample_i, .bias_level_o,
        .mod_div_o, .common_mode_out_en_o, .xtal_en_o, .data_ready_o, .serial_data_clock_o,
        .serial_data_out_o, .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i, .spi_resp_i, .spi_miso_o,
        .spi_miso_oe_o, .spi_cmd_o, .spi_cmd_valid_o);
    host_reader host (.clk_i(ref_clk_i), .srst_i(srst_i), .data_ready_i(data_ready_o),
        .bit_strobe_i(serial_data_clock_o), .data_i(serial_data_out_o), .word_o(hw),
        .bits_o(hbits), .gap_o(hgap), .words_o(hcount));

    // =====================================================
    // Clock, timeout and command capture
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (spi_cmd_valid_o === 1'b1) got_cmd <= spi_cmd_o;
        if (cycles == LIMIT) begin
            num_errors++;
            test_done();
        end
    end

    // =====================================================
    // Helpers
    task automatic test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic do_reset();
        srst_i <= 1'b1;
        tick(16);
        srst_i <= 1'b0;
        tick(2);
    endtask : do_reset
    task automatic apply(input logic [3:0] k, input logic [1:0] st, input logic f,
                         input logic [1:0] d);
        op_select_pins_i <= k;
        {bank_high_standby_i, bank_low_standby_i} <= st;
        filter_sel_i <= f;
        {decim_sel_hi_i, decim_sel_lo_i} <= d;
        tick(2);
        sync_i <= 1'b1;
        tick(1);
        sync_i <= 1'b0;
        tick(6);
    endtask : apply
    task automatic wait_word();
        int n;
        n = 0;
        while (data_ready_o !== 1'b1 && n < 6000) begin tick(1); n++; end
        tick(2);
        while (hbits !== 6'h20 && n < 9000) begin tick(1); n++; end
        if (n >= 6000) check(32'h1, 32'h0);
    endtask : wait_word
    task automatic pitch(output int q);
        int n;
        n = 0;
        while (data_ready_o !== 1'b1 && n < 6000) begin tick(1); n++; end
        tick(1);
        q = 1;
        while (data_ready_o !== 1'b1 && q < 6000) begin tick(1); q++; end
    endtask : pitch
    task automatic check_words(input logic [7:0] stby, input logic flt, input logic fst,
                               input logic f);
        for (int c = 0; c < 8; c++) begin
            if (stby[c]) check(hw[c], 32'h0);
            else check(hw[c], {flt, fst, f, sat_i[c], 1'b0, 3'(c), sample_i[24*c +: 24]});
        end
    endtask : check_words
    task automatic spi_xfer(input logic [15:0] c, input logic [15:0] r);
        spi_resp_i <= r;
        spi_cs_n_i <= 1'b0;
        tick(3);
        for (int i = 15; i >= 0; i--) begin
            spi_mosi_i <= c[i];
            tick(3);
            check(32'(spi_miso_o), 32'(r[i]));
            spi_sclk_i <= 1'b1;
            tick(3);
            spi_sclk_i <= 1'b0;
        end
        tick(4);
        check(32'(got_cmd), 32'(c));
        check(32'(spi_miso_oe_o), 32'h1);
        spi_cs_n_i <= 1'b1;
        tick(3);
        check(32'(spi_miso_oe_o), 32'h0);
    endtask : spi_xfer
    function automatic logic [1:0] exp_pwr(input logic [3:0] k);
        case (k)
            4'hC: return PWR_ECO;
            4'hD: return PWR_MEDIAN;
            4'hE, 4'hF: return PWR_FAST;
            default: return k[3:2];
        endcase
    endfunction : exp_pwr
    function automatic logic [5:0] exp_md(input logic [1:0] w);
        return (w == 2'h2) ? `MOD_DIV_FAST : (w == 2'h1) ? `MOD_DIV_MEDIAN : `MOD_DIV_ECO;
    endfunction : exp_md
    function automatic logic [7:0] exp_n(input logic [3:0] k);
        if (k == 4'hE) return 8'h02;
        if (k[3:2] == 2'h3) return 8'h01;
        return 8'h01 << k[1:0];
    endfunction : exp_n

    // =====================================================
    // Tests
    initial begin
        {sync_i, filter_sel_i, decim_sel_hi_i, decim_sel_lo_i, op_select_pins_i} = 8'h00;
        {bank_low_standby_i, bank_high_standby_i, crc_err_i, mem_flip_i} = 4'h0;
        {clk_missing_i, sat_i, spi_sclk_i, spi_mosi_i} = 11'h000;
        {spi_cs_n_i, spi_resp_i, srst_i} = {1'b1, 16'h0000, 1'b1};
        for (int c = 0; c < 8; c++) sample_i[24*c +: 24] = 24'hC35A00 + 24'(c * 17);
        tick(16);
        srst_i <= 1'b0;
        tick(2);
        check({bias_level_o, mod_div_o, common_mode_out_en_o, xtal_en_o}, 32'h0083);
        check(32'(spi_miso_oe_o), 32'h0);
        // Decimation chosen per power keeps one word inside one period
        for (int k = 0; k < 16; k++) begin
            apply(4'(k), 2'h0, 1'b1, exp_pwr(4'(k)));
            check(32'(bias_level_o), 32'(exp_pwr(4'(k))));
            check(32'(mod_div_o), 32'(exp_md(exp_pwr(4'(k)))));
            wait_word();
            check_words(8'h00, 1'b0, 1'b1, 1'b1);
            check(32'(hgap), 32'(exp_n(4'(k))));
            if (k < 12) begin
                wait_word();
                check_words(8'h00, 1'b0, 1'b0, 1'b1);
            end else begin
                rec = hcount;
                tick(1500);
                check(32'(hcount), 32'(rec));
            end
        end
        for (int d = 0; d < 4; d++) begin
            apply(4'h8, 2'h0, 1'b0, 2'(d));
            pitch(p);
            check(p, 4 * dec_tab[d]);
            pitch(p);
            check(p, 4 * dec_tab[d]);
        end
        for (int s = 0; s < 4; s++) begin
            sat_i <= 8'h5A ^ {4{2'(s)}};
            apply(4'h8, 2'(s), s[0], 2'h0);
            wait_word();
            check_words({{4{s[1]}}, {4{s[0]}}}, 1'b0, 1'b1, s[0]);
            check(32'(common_mode_out_en_o), 32'(!s[0]));
            check(32'(xtal_en_o), 32'(!s[1]));
        end
        op_select_pins_i <= 4'h0;
        tick(20);
        check(32'(mod_div_o), 32'(`MOD_DIV_FAST));
        check(32'(bias_level_o), 32'(PWR_FAST));
        // The no-fault pass proves reset clears the sticky flag
        for (int f = 0; f < 4; f++) begin
            do_reset();
            apply(4'h8, 2'h0, 1'b1, 2'h0);
            {clk_missing_i, mem_flip_i, crc_err_i} <= 3'h1 << f;
            tick(1);
            {clk_missing_i, mem_flip_i, crc_err_i} <= 3'h0;
            wait_word();
            check_words(8'h00, f < 3, 1'b1, 1'b1);
        end
        spi_xfer(16'hA55A, 16'h3C96);
        spi_xfer(16'h0E01, 16'hC369);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
